// *** src/meter_serial_pkg.sv ***
package meter_serial_pkg;

   // ======================================================================
   // Clock and supply-monitor timing
   // ======================================================================
   localparam int CLK_HZ = 10_000_000;
   // Least time a supply comparator level must hold before the state flips.
   localparam int SUPPLY_FILTER_NS = 10_000;
   localparam int SUPPLY_FILTER_CYCLES = (SUPPLY_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int FILTER_W = 8;

   // ======================================================================
   // Serial frame layout: 8-bit command, then a 24-bit data word
   // ======================================================================
   localparam int CMD_W = 8;
   localparam int DATA_W = 24;
   localparam int ADDR_W = 6;
   localparam int CMD_WRITE_BIT = 7;
   localparam int BITCNT_W = 6;
   localparam logic [BITCNT_W-1:0] CMD_END = 6'h08;
   localparam logic [BITCNT_W-1:0] LAST_BIT = 6'h1F;
   localparam logic [BITCNT_W-1:0] FRAME_END = 6'h20;

   // ======================================================================
   // Register addresses carried in the command byte
   // ======================================================================
   localparam logic [ADDR_W-1:0] ADDR_WAVEFORM = 6'h01;
   localparam logic [ADDR_W-1:0] ADDR_ACT_ENERGY = 6'h02;
   localparam logic [ADDR_W-1:0] ADDR_APP_ENERGY = 6'h03;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 6'h04;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 6'h05;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS_CLR = 6'h06;

   // ======================================================================
   // Interrupt status and mask fields
   // ======================================================================
   localparam int FLAG_W = 4;
   localparam int FLAG_ACT_HALF = 0;
   localparam int FLAG_APP_HALF = 1;
   localparam int FLAG_WAVE_READY = 2;
   localparam int FLAG_SUPPLY_DROP = 3;
   localparam logic [FLAG_W-1:0] MASK_RESET = 4'h0;
   // The supply-drop position can never be enabled onto the request line.
   localparam logic [FLAG_W-1:0] MASK_WRITABLE = 4'h7;
   localparam logic [DATA_W-1:0] ACC_RESET = 24'h000000;

   // ======================================================================
   // Carriers
   // ======================================================================
   typedef struct packed {
      logic valid;
      logic signed [15:0] active;
      logic [15:0] apparent;
   } power_sample_t;

   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } wave_sample_t;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;

endpackage : meter_serial_pkg

// *** src/meter_serial_pins.sv ***
// Notes on behaviour
// - While the active-low reset pin is low, all logic including the serial port is held in reset.
// - The interrupt request pin is open drain and active low, pulled low only to signal an interrupt.
// - Active energy half level, apparent energy half level and waveform sample ready are each maskable sources.
// - The device joins a serial transfer only while the active-low chip select is held low.
// - Serial input bits are captured on the falling edge of the serial clock.
// - Serial output bits are launched on the rising edge of the serial clock.
// - The serial data output is released except while returning read data.
// - All serial transfers are timed by the host's serial clock, which the device only receives.
// - While the analog supply is below threshold the device accumulates no energy.
// - Supply-low detection uses hysteresis and a filter so supply noise does not toggle it.
// - A supply drop below threshold sets the supply-drop flag in the interrupt status.
// - The supply-drop flag is permanently masked and never drives the interrupt request.
`timescale 1ns/1ps
`default_nettype none

module meter_serial_pins (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic reset_pin_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout_o,
   output logic dout_oe,
   output logic irq_o,
   output logic irq_oe,
   input wire logic supply_below_trip,
   input wire logic supply_above_release,
   input wire meter_serial_pkg::power_sample_t power_in,
   input wire meter_serial_pkg::wave_sample_t wave_in,
   output logic energy_inactive
);

   // ======================================================================
   // Reset pin and system reset
   // ======================================================================
   logic rst_pin_s1_r;
   logic rst_pin_s2_r;
   logic core_rst;
   logic link_rst_r;

   // The reset pin is asynchronous to the core, so it is synchronised first.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rst_pin_s1_r <= 1'b0;
         rst_pin_s2_r <= 1'b0;
      end else begin
         rst_pin_s1_r <= reset_pin_n;
         rst_pin_s2_r <= rst_pin_s1_r;
      end
   end

   assign core_rst = sys_rst | ~rst_pin_s2_r;

   // A registered copy drives the link side, which has no free-running clock.
   always_ff @(posedge clk_sys) begin
      link_rst_r <= core_rst;
   end

   // ======================================================================
   // Link-to-core crossings: chip select level and two event toggles
   // ======================================================================
   logic cs_s1_r;
   logic cs_s2_r;
   logic cs_s3_r;
   logic wr_tgl_r;
   logic clr_tgl_r;
   logic wr_s1_r;
   logic wr_s2_r;
   logic wr_s3_r;
   logic clr_s1_r;
   logic clr_s2_r;
   logic clr_s3_r;
   logic frame_start;
   logic wr_event;
   logic clr_event;

   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         cs_s3_r <= 1'b1;
         wr_s1_r <= 1'b0;
         wr_s2_r <= 1'b0;
         wr_s3_r <= 1'b0;
         clr_s1_r <= 1'b0;
         clr_s2_r <= 1'b0;
         clr_s3_r <= 1'b0;
      end else begin
         cs_s1_r <= cs_n;
         cs_s2_r <= cs_s1_r;
         cs_s3_r <= cs_s2_r;
         wr_s1_r <= wr_tgl_r;
         wr_s2_r <= wr_s1_r;
         wr_s3_r <= wr_s2_r;
         clr_s1_r <= clr_tgl_r;
         clr_s2_r <= clr_s1_r;
         clr_s3_r <= clr_s2_r;
      end
   end

   assign frame_start = cs_s3_r & ~cs_s2_r;
   assign wr_event = wr_s2_r ^ wr_s3_r;
   assign clr_event = clr_s2_r ^ clr_s3_r;

   // ======================================================================
   // Supply monitor with hysteresis and filter
   // ======================================================================
   logic trip_s1_r;
   logic trip_s2_r;
   logic rel_s1_r;
   logic rel_s2_r;
   logic supply_low_r;
   logic [meter_serial_pkg::FILTER_W-1:0] filt_cnt_r;
   logic filt_cond;
   logic supply_drop_set;

   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         trip_s1_r <= 1'b1;
         trip_s2_r <= 1'b1;
         rel_s1_r <= 1'b0;
         rel_s2_r <= 1'b0;
      end else begin
         trip_s1_r <= supply_below_trip;
         trip_s2_r <= trip_s1_r;
         rel_s1_r <= supply_above_release;
         rel_s2_r <= rel_s1_r;
      end
   end

   // Two thresholds give the hysteresis; the count gives the filtering.
   assign filt_cond = supply_low_r ? rel_s2_r : trip_s2_r;
   assign supply_drop_set = ~supply_low_r & filt_cond &
      (filt_cnt_r == meter_serial_pkg::FILTER_W'(meter_serial_pkg::SUPPLY_FILTER_CYCLES - 1));

   // The device starts inactive, so power-up waits for a settled supply.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         supply_low_r <= 1'b1;
         filt_cnt_r <= '0;
      end else if (!filt_cond) begin
         filt_cnt_r <= '0;
      end else if (filt_cnt_r == meter_serial_pkg::FILTER_W'(meter_serial_pkg::SUPPLY_FILTER_CYCLES - 1)) begin
         supply_low_r <= ~supply_low_r;
         filt_cnt_r <= '0;
      end else begin
         filt_cnt_r <= filt_cnt_r + 1'b1;
      end
   end

   assign energy_inactive = supply_low_r;

   // ======================================================================
   // Energy accumulation
   // ======================================================================
   logic [meter_serial_pkg::DATA_W-1:0] act_acc_r;
   logic [meter_serial_pkg::DATA_W-1:0] app_acc_r;
   logic [meter_serial_pkg::DATA_W-1:0] act_acc_nxt;
   logic [meter_serial_pkg::DATA_W-1:0] app_acc_nxt;
   logic [meter_serial_pkg::DATA_W-1:0] wave_r;
   logic act_half_set;
   logic app_half_set;
   logic accumulate;

   assign accumulate = power_in.valid & ~supply_low_r;
   assign act_acc_nxt = act_acc_r + {{8{power_in.active[15]}}, power_in.active};
   assign app_acc_nxt = app_acc_r + {8'h00, power_in.apparent};
   // Half level means the magnitude reaches 2^22 (signed) or 2^23 (unsigned).
   assign act_half_set = accumulate & (act_acc_nxt[23] ^ act_acc_nxt[22]) & ~(act_acc_r[23] ^ act_acc_r[22]);
   assign app_half_set = accumulate & app_acc_nxt[23] & ~app_acc_r[23];

   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         act_acc_r <= meter_serial_pkg::ACC_RESET;
         app_acc_r <= meter_serial_pkg::ACC_RESET;
      end else if (accumulate) begin
         act_acc_r <= act_acc_nxt;
         app_acc_r <= app_acc_nxt;
      end
   end

   // Waveform samples keep flowing while the supply is low; only energy stops.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         wave_r <= meter_serial_pkg::ACC_RESET;
      end else if (wave_in.valid) begin
         wave_r <= wave_in.data;
      end
   end

   // ======================================================================
   // Interrupt status, mask and request pin
   // ======================================================================
   logic [meter_serial_pkg::FLAG_W-1:0] status_r;
   logic [meter_serial_pkg::FLAG_W-1:0] mask_r;
   logic [meter_serial_pkg::FLAG_W-1:0] flag_set;
   logic [meter_serial_pkg::FLAG_W-1:0] flag_clr;
   logic [meter_serial_pkg::ADDR_W-1:0] wr_addr_r;
   logic [meter_serial_pkg::DATA_W-1:0] wr_data_r;
   logic [meter_serial_pkg::FLAG_W-1:0] snap_status_r;

   always_comb begin
      flag_set = '0;
      flag_set[meter_serial_pkg::FLAG_ACT_HALF] = act_half_set;
      flag_set[meter_serial_pkg::FLAG_APP_HALF] = app_half_set;
      flag_set[meter_serial_pkg::FLAG_WAVE_READY] = wave_in.valid;
      flag_set[meter_serial_pkg::FLAG_SUPPLY_DROP] = supply_drop_set;
   end

   // Only flags that the host saw in its snapshot are cleared by the read.
   assign flag_clr = clr_event ? snap_status_r : '0;

   // A new event in the clearing cycle survives because set is applied last.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~flag_clr) | flag_set;
      end
   end

   // Mask writes arrive as a toggle; address and data are stable by then.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         mask_r <= meter_serial_pkg::MASK_RESET;
      end else if (wr_event && wr_addr_r == meter_serial_pkg::ADDR_IRQ_MASK) begin
         mask_r <= wr_data_r[meter_serial_pkg::FLAG_W-1:0] & meter_serial_pkg::MASK_WRITABLE;
      end
   end

   // The line is only ever pulled low; the external pull-up releases it.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         irq_oe <= 1'b0;
      end else begin
         irq_oe <= |(status_r & mask_r & meter_serial_pkg::MASK_WRITABLE);
      end
   end

   assign irq_o = 1'b0;

   // ======================================================================
   // Snapshot taken at frame start
   // ======================================================================
   logic [meter_serial_pkg::DATA_W-1:0] snap_wave_r;
   logic [meter_serial_pkg::DATA_W-1:0] snap_act_r;
   logic [meter_serial_pkg::DATA_W-1:0] snap_app_r;
   logic [meter_serial_pkg::FLAG_W-1:0] snap_mask_r;

   // The link reads these while they are frozen, which is the crossing.
   // The host must leave a few core clocks between select low and first edge.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         snap_wave_r <= '0;
         snap_act_r <= '0;
         snap_app_r <= '0;
         snap_mask_r <= '0;
         snap_status_r <= '0;
      end else if (frame_start) begin
         snap_wave_r <= wave_r;
         snap_act_r <= act_acc_r;
         snap_app_r <= app_acc_r;
         snap_mask_r <= mask_r;
         snap_status_r <= status_r;
      end
   end

   // ======================================================================
   // Serial link, clocked by the host's serial clock
   // ======================================================================
   logic frame_arst;
   logic [meter_serial_pkg::BITCNT_W-1:0] bit_cnt_r;
   logic [meter_serial_pkg::CMD_W-1:0] cmd_r;
   logic [meter_serial_pkg::DATA_W-1:0] shift_in_r;
   logic [meter_serial_pkg::DATA_W-1:0] shift_out_r;
   logic [meter_serial_pkg::DATA_W-1:0] rd_word;
   logic [meter_serial_pkg::ADDR_W-1:0] cmd_addr;
   logic cmd_write;
   logic dout_r;
   logic oe_r;

   // Deselect ends the frame even if the serial clock has stopped.
   assign frame_arst = cs_n | link_rst_r;
   assign cmd_addr = cmd_r[meter_serial_pkg::ADDR_W-1:0];
   assign cmd_write = cmd_r[meter_serial_pkg::CMD_WRITE_BIT];

   // Input bits are sampled on the falling edge of the host clock.
   always_ff @(negedge sclk or posedge frame_arst) begin
      if (frame_arst) begin
         bit_cnt_r <= '0;
         cmd_r <= '0;
         shift_in_r <= '0;
      end else begin
         if (bit_cnt_r < meter_serial_pkg::CMD_END) begin
            cmd_r <= {cmd_r[meter_serial_pkg::CMD_W-2:0], din};
         end else if (bit_cnt_r < meter_serial_pkg::FRAME_END) begin
            shift_in_r <= {shift_in_r[meter_serial_pkg::DATA_W-2:0], din};
         end
         if (bit_cnt_r != meter_serial_pkg::FRAME_END) begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
         end
      end
   end

   // Completed writes and status-clear reads hand off to the core by toggle.
   always_ff @(negedge sclk or posedge link_rst_r) begin
      if (link_rst_r) begin
         wr_tgl_r <= 1'b0;
         clr_tgl_r <= 1'b0;
         wr_addr_r <= '0;
         wr_data_r <= '0;
      end else if (!cs_n && bit_cnt_r == meter_serial_pkg::LAST_BIT) begin
         if (cmd_write) begin
            wr_addr_r <= cmd_addr;
            wr_data_r <= {shift_in_r[meter_serial_pkg::DATA_W-2:0], din};
            wr_tgl_r <= ~wr_tgl_r;
         end else if (cmd_addr == meter_serial_pkg::ADDR_IRQ_STATUS_CLR) begin
            clr_tgl_r <= ~clr_tgl_r;
         end
      end
   end

   // Read data comes from the frozen snapshot; unmapped addresses read zero.
   always_comb begin
      rd_word = '0;
      unique case (cmd_addr)
         meter_serial_pkg::ADDR_WAVEFORM: rd_word = snap_wave_r;
         meter_serial_pkg::ADDR_ACT_ENERGY: rd_word = snap_act_r;
         meter_serial_pkg::ADDR_APP_ENERGY: rd_word = snap_app_r;
         meter_serial_pkg::ADDR_IRQ_MASK: rd_word[meter_serial_pkg::FLAG_W-1:0] = snap_mask_r;
         meter_serial_pkg::ADDR_IRQ_STATUS: rd_word[meter_serial_pkg::FLAG_W-1:0] = snap_status_r;
         meter_serial_pkg::ADDR_IRQ_STATUS_CLR: rd_word[meter_serial_pkg::FLAG_W-1:0] = snap_status_r;
         default: rd_word = '0;
      endcase
   end

   // Output bits are launched on the rising edge, half a period before capture.
   always_ff @(posedge sclk or posedge frame_arst) begin
      if (frame_arst) begin
         dout_r <= 1'b0;
         oe_r <= 1'b0;
         shift_out_r <= '0;
      end else if (bit_cnt_r == meter_serial_pkg::CMD_END && !cmd_write) begin
         dout_r <= rd_word[meter_serial_pkg::DATA_W-1];
         shift_out_r <= {rd_word[meter_serial_pkg::DATA_W-2:0], 1'b0};
         oe_r <= 1'b1;
      end else if (bit_cnt_r == meter_serial_pkg::FRAME_END) begin
         oe_r <= 1'b0;
      end else if (oe_r) begin
         dout_r <= shift_out_r[meter_serial_pkg::DATA_W-1];
         shift_out_r <= {shift_out_r[meter_serial_pkg::DATA_W-2:0], 1'b0};
      end
   end

   assign dout_o = dout_r;
   assign dout_oe = oe_r & ~cs_n;

endmodule : meter_serial_pins

`default_nettype wire

// *** testbench/meter_serial_pins_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checker
module meter_serial_pins_checker (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic reset_pin_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout_o,
   input wire logic dout_oe,
   input wire logic irq_o,
   input wire logic irq_oe,
   input wire logic supply_below_trip,
   input wire logic supply_above_release,
   input wire meter_serial_pkg::power_sample_t power_in,
   input wire meter_serial_pkg::wave_sample_t wave_in,
   input wire logic energy_inactive
);
   logic [7:0] below_r, above_r, quiet_r;
   logic [5:0] falls_r;
   logic dout_fall_r;
   logic wr_frame_r;
   // Run lengths of each comparator level; they saturate so a long run stays long.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         below_r <= 8'h00;
         above_r <= 8'h00;
      end else begin
         below_r <= !supply_below_trip ? 8'h00 : below_r + {7'h00, below_r != 8'hFF};
         above_r <= !supply_above_release ? 8'h00 : above_r + {7'h00, above_r != 8'hFF};
      end
   end
   // Quiet span: no frame and no sample, so nothing is allowed to move the request line.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !cs_n || power_in.valid || wave_in.valid) begin
         quiet_r <= 8'h00;
      end else begin
         quiet_r <= quiet_r + {7'h00, quiet_r != 8'hFF};
      end
   end
   // Falls seen in this frame; chip select high clears it because the clock stops between frames.
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         falls_r <= 6'h00;
      end else begin
         falls_r <= falls_r + {5'h00, falls_r != 6'h3F};
      end
   end
   // Output value as it stood at the last falling edge, and the write bit of this frame.
   // Write frames never drive the output, so the window check needs the command's top bit.
   always_ff @(negedge sclk) begin
      dout_fall_r <= dout_o;
      if (falls_r == 6'h00) begin
         wr_frame_r <= din;
      end
   end
   pin_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !reset_pin_n [*5] |=> !irq_oe && !dout_oe && energy_inactive) else $error("pin reset not honoured");
   irq_polarity_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      irq_oe |-> !irq_o) else $error("request line not pulled low");
   cs_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cs_n |-> !dout_oe) else $error("output driven while deselected");
   supply_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      below_r == 8'h6E |-> energy_inactive) else $error("low supply not made inactive");
   drop_filter_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !reset_pin_n)
      $rose(energy_inactive) |-> below_r >= 8'h64) else $error("inactive state entered too soon");
   release_filter_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !reset_pin_n)
      $fell(energy_inactive) |-> above_r >= 8'h64) else $error("inactive state left too soon");
   quiet_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst || !reset_pin_n)
      quiet_r >= 8'h0A |-> $stable(irq_oe)) else $error("request moved with no cause");
   oe_window_a: assert property (@(negedge sclk) disable iff (cs_n || sys_rst)
      dout_oe == (!wr_frame_r && falls_r >= 6'h08 && falls_r <= 6'h1F)) else $error("output enable outside data phase");
   launch_edge_a: assert property (@(posedge sclk) disable iff (cs_n || sys_rst)
      dout_oe |-> dout_o == dout_fall_r) else $error("output changed on a falling edge");
endmodule : meter_serial_pins_checker

bind meter_serial_pins meter_serial_pins_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reset_pin_n(reset_pin_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
   .irq_o(irq_o), .irq_oe(irq_oe), .supply_below_trip(supply_below_trip),
   .supply_above_release(supply_above_release), .power_in(power_in), .wave_in(wave_in),
   .energy_inactive(energy_inactive));
`default_nettype wire

// *** testbench/meter_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Serial bus master
module meter_host_model (
   output var logic sclk,
   output var logic cs_n,
   output var logic din,
   input wire logic dout_o,
   input wire logic dout_oe
);
   logic last = 1'b0;
   // A released data line is not trusted to keep its last value.
   wire logic line = dout_oe ? dout_o : ~last;
   // Idle bus: deselected, clock parked high and still.
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
   end
   // One frame, cut short when nbits is below 32; read bits are taken at falling edges.
   task automatic frame(input logic [7:0] cmd, input logic [23:0] wdata, input int nbits,
                        output logic [23:0] rdata);
      logic [31:0] word;
      word = {cmd, wdata};
      rdata = 24'h000000;
      cs_n = 1'b0;
      #600;
      for (int i = 0; i < nbits; i++) begin
         #1 din = word[31 - i];
         #2 sclk = 1'b0;
         last = line;
         if (i >= 8) begin
            rdata = {rdata[22:0], line};
         end
         #3 sclk = 1'b1;
      end
      #3 cs_n = 1'b1;
      din = ~din;
      #600;
   endtask : frame
endmodule : meter_host_model
`default_nettype wire

// *** testbench/meter_serial_pins_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench for the serial pin block
module meter_serial_pins_test;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic reset_pin_n = 1'b1;
   logic below = 1'b0;
   logic above = 1'b1;
   meter_serial_pkg::power_sample_t power_in = '0;
   meter_serial_pkg::wave_sample_t wave_in = '0;
   logic sclk, cs_n, din, dout_o, dout_oe, irq_o, irq_oe, energy_inactive;
   logic [23:0] rd;
   int mismatches = 0;
   int n_checks = 0;
   // Core clock at 10 MHz.
   always #50 clk_sys = ~clk_sys;
   meter_serial_pins dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .sclk(sclk),
      .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .irq_o(irq_o), .irq_oe(irq_oe),
      .supply_below_trip(below), .supply_above_release(above), .power_in(power_in), .wave_in(wave_in),
      .energy_inactive(energy_inactive));
   meter_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic cycles(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cycles
   task automatic rd_reg(input logic [5:0] a, output logic [23:0] d);
      host.frame({2'b00, a}, 24'h000000, 32, d);
   endtask : rd_reg
   task automatic wr_reg(input logic [5:0] a, input logic [23:0] v);
      host.frame({2'b10, a}, v, 32, rd);
   endtask : wr_reg
   // Samples are spaced two cycles apart, as the sources would never burst.
   task automatic feed(input int n, input logic [15:0] act, input logic [15:0] app);
      repeat (n) begin
         @(negedge clk_sys);
         power_in = {1'b1, act, app};
         @(negedge clk_sys);
         power_in.valid = 1'b0;
      end
   endtask : feed
   task automatic wave(input logic [23:0] d);
      @(negedge clk_sys);
      wave_in = {1'b1, d};
      @(negedge clk_sys);
      wave_in.valid = 1'b0;
      cycles(3);
   endtask : wave
   task automatic t_reset();
      check({22'h0, dout_oe, irq_oe}, 24'h000000);
      check({23'h0, energy_inactive}, 24'h000001);
      cycles(110);
      check({23'h0, energy_inactive}, 24'h000000);
      rd_reg(meter_serial_pkg::ADDR_IRQ_MASK, rd);
      check(rd, 24'h000000);
   endtask : t_reset
   task automatic t_accum();
      feed(3, 16'h0100, 16'h0200);
      rd_reg(meter_serial_pkg::ADDR_ACT_ENERGY, rd);
      check(rd, 24'h000300);
      rd_reg(meter_serial_pkg::ADDR_APP_ENERGY, rd);
      check(rd, 24'h000600);
      check({23'h0, dout_oe}, 24'h000000);
   endtask : t_accum
   // Supply-drop bit is not writable, so the mask reads back without it.
   task automatic t_wave_irq();
      wr_reg(meter_serial_pkg::ADDR_IRQ_MASK, 24'h00000F);
      rd_reg(meter_serial_pkg::ADDR_IRQ_MASK, rd);
      check(rd, 24'h000007);
      check({23'h0, irq_oe}, 24'h000000);
      wave(24'hA5C3E1);
      check({22'h0, irq_oe, irq_o}, 24'h000002);
      rd_reg(meter_serial_pkg::ADDR_WAVEFORM, rd);
      check(rd, 24'hA5C3E1);
      host.frame({2'b00, meter_serial_pkg::ADDR_IRQ_STATUS_CLR}, 24'h000000, 20, rd);
      rd_reg(meter_serial_pkg::ADDR_IRQ_STATUS, rd);
      check(rd, 24'h000004);
      rd_reg(meter_serial_pkg::ADDR_IRQ_STATUS_CLR, rd);
      check(rd, 24'h000004);
      check({23'h0, irq_oe}, 24'h000000);
   endtask : t_wave_irq
   task automatic t_half();
      feed(129, 16'h7FFF, 16'hFFFF);
      check({23'h0, irq_oe}, 24'h000001);
      rd_reg(meter_serial_pkg::ADDR_ACT_ENERGY, rd);
      check(rd, 24'h40827F);
      rd_reg(meter_serial_pkg::ADDR_APP_ENERGY, rd);
      check(rd, 24'h81057F);
      rd_reg(meter_serial_pkg::ADDR_IRQ_STATUS_CLR, rd);
      check(rd, 24'h000003);
      check({23'h0, irq_oe}, 24'h000000);
   endtask : t_half
   // A short dip must be filtered out; a long one stops accumulation.
   task automatic t_supply();
      cycles(1);
      below = 1'b1;
      above = 1'b0;
      cycles(50);
      below = 1'b0;
      above = 1'b1;
      cycles(5);
      check({23'h0, energy_inactive}, 24'h000000);
      below = 1'b1;
      above = 1'b0;
      cycles(115);
      check({22'h0, energy_inactive, irq_oe}, 24'h000002);
      feed(2, 16'h0100, 16'h0100);
      rd_reg(meter_serial_pkg::ADDR_ACT_ENERGY, rd);
      check(rd, 24'h40827F);
      rd_reg(meter_serial_pkg::ADDR_IRQ_STATUS, rd);
      check(rd, 24'h000008);
      cycles(1);
      below = 1'b0;
      above = 1'b1;
      cycles(110);
      check({23'h0, energy_inactive}, 24'h000000);
   endtask : t_supply
   task automatic t_pin();
      wave(24'h000001);
      reset_pin_n = 1'b0;
      cycles(10);
      check({22'h0, energy_inactive, irq_oe}, 24'h000002);
      reset_pin_n = 1'b1;
      cycles(8);
      rd_reg(meter_serial_pkg::ADDR_IRQ_MASK, rd);
      check(rd, 24'h000000);
   endtask : t_pin
   // Main sequence after ten reset cycles.
   initial begin
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_reset();
      t_accum();
      t_wave_irq();
      t_half();
      t_supply();
      t_pin();
      print_verdict();
   end
   // Watchdog: the sequence needs about 900 cycles, so 10000 leaves ample margin.
   initial begin
      #1000000;
      mismatches++;
      print_verdict();
   end
endmodule : meter_serial_pins_test
`default_nettype wire
